// >>> design/acc_ctrl.sv
/*
 * Converter control top: configuration and limit registers, single-shot and
 * continuous sequencing, alert and ready pin, alert-response bookkeeping.
 * Assumes an I2C slave on ref_clk delivers decoded writes, reads, general
 * call bytes and alert-response wins as one-cycle pulses, and a digital
 * filter presents the finished sample on filterData.
 */
// Behaviour
// - all timing from an internal 1 MHz tick; no external converter clock.
// - three-bit rate picks 8 to 860 SPS; conversion time is one over rate.
// - traditional mode asserts above upper limit, releases only below lower limit.
// - window mode asserts when result above upper or below lower limit.
// - latched alert holds until alert response won or result register read.
// - polarity selects active high or low; low is the default.
// - fault queue needs one, two or four successive readings beyond a limit.
// - queue code 11 releases the pin; the comparator keeps counting with a four-reading queue.
// - upper MSB 1, lower MSB 0 makes pin a ready flag; polarity kept.
// - continuous ready mode gives about 8 us pulse per conversion.
// - single-shot ready mode with polarity 0 drives pin low at completion.
// - cleared latched alert can reassert; clearing leaves conversion untouched.
// - pin is open drain, only pulls low, released when disabled.
// - host sends alert-response address; asserting devices answer with address.
// - lowest address wins arbitration and clears; losers keep alert.
// - window mode status bit is 1 for upper, 0 for lower violation.
// - reset loads defaults and enters power-down with logic active.
// - general call command 06h resets like power-up.
// - mode bit 1 is single-shot, powered down until started; default.
// - start bit powers up in 25 us, runs one conversion; ignored while busy.
// - mode bit 0 stores each result and starts the next at once.
// - window mode and rate written mid-conversion apply from the next conversion; other fields at once.
// - registers move as two bytes, MSB first, chosen by two-bit pointer.
`timescale 1ns/1ns
`default_nettype none
`include "acc_defines.svh"

module acc_ctrl #(
    parameter int OSC_DIV = `ACC_OSC_DIV
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic cfgWrite,
    input wire acc_pkg::acc_cfg_t cfgIn,
    input wire logic startIn,
    input wire logic limitWrite,
    input wire acc_pkg::acc_limits_t limitsIn,
    input wire logic regRead,
    input wire logic [1:0] pointer,
    input wire logic gcByte,
    input wire logic [7:0] gcCommand,
    input wire logic araWon,
    input wire logic [15:0] filterData,
    output acc_pkg::acc_cfg_t cfg,
    output acc_pkg::acc_limits_t limits,
    output logic conversionStartBit,
    output logic [15:0] convResult,
    output logic [15:0] readWord,
    output logic alertPending,
    output logic alertStatusBit,
    output logic alertPinOut,
    output logic alertPinOe
);
    acc_pkg::acc_state_t state;
    acc_pkg::acc_state_t next_state;
    acc_pkg::acc_cfg_t runCfg;
    logic rst;
    logic startReq;
    logic resultRead;
    logic tick;
    logic timerDone;
    logic timerLoad;
    logic loadWake;
    logic convDone;
    logic trigger;
    logic clearCond;
    logic statusHigh;
    logic alertFlag;
    logic readyMode;
    logic readyLevel;
    logic readyPulse;
    logic [7:0] pulseTicks;
    logic pinAsserted;

    // ==========================================================
    // internal reset: pin reset or general call reset command
    assign rst = srst || (gcByte && gcCommand == `ACC_GC_RESET);
    assign startReq = cfgWrite && startIn;
    assign resultRead = regRead && (pointer == `ACC_PTR_CONV);
    assign readyMode = limits.upperLimit[15] && !limits.lowerLimit[15];

    // ==========================================================
    // configuration and limits, defaults on either reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg <= '{singleShot: `ACC_RST_MODE, rateSelect: `ACC_RST_RATE,
                     windowMode: `ACC_RST_WINDOW, alertPolarity: `ACC_RST_POL,
                     alertLatchEnable: `ACC_RST_LATCH, faultQueue: `ACC_RST_QUEUE};
        end else if (cfgWrite) begin
            cfg <= cfgIn;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            limits <= '{upperLimit: `ACC_RST_UPPER, lowerLimit: `ACC_RST_LOWER};
        end else if (limitWrite) begin
            limits <= limitsIn;
        end
    end

    // ==========================================================
    // sequencing: off, power-up wait, converting
    always_comb begin
        next_state = state;
        case (state)
            acc_pkg::ST_OFF: begin
                // continuous mode also needs the power-up wait
                if (startReq || !cfg.singleShot) begin
                    next_state = acc_pkg::ST_WAKE;
                end
            end
            acc_pkg::ST_WAKE: begin
                if (timerDone) begin
                    next_state = acc_pkg::ST_CONV;
                end
            end
            acc_pkg::ST_CONV: begin
                // start requests here fall through: ignored while busy
                if (timerDone) begin
                    next_state = cfg.singleShot ? acc_pkg::ST_OFF : acc_pkg::ST_CONV;
                end
            end
            default: next_state = acc_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= acc_pkg::ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    assign convDone = (state == acc_pkg::ST_CONV) && timerDone;
    assign loadWake = (state == acc_pkg::ST_OFF);
    assign timerLoad = (next_state == acc_pkg::ST_WAKE && state == acc_pkg::ST_OFF)
        || (state == acc_pkg::ST_WAKE && timerDone)
        || (convDone && !cfg.singleShot);
    // start bit reads 1 only while powered down and idle
    assign conversionStartBit = (state == acc_pkg::ST_OFF);

    // ==========================================================
    // settings frozen at each conversion start
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            runCfg <= '0;
        end else if (timerLoad && !loadWake) begin
            runCfg <= cfg;
        end
    end

    acc_conv_timer #(
        .OSC_DIV(OSC_DIV)
    ) u_timer (
        .ref_clk(ref_clk),
        .srst(rst),
        .load(timerLoad),
        .loadWake(loadWake),
        .rateSelect(cfg.rateSelect),
        .tick(tick),
        .done(timerDone)
    );

    // ==========================================================
    // result register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            convResult <= 16'h0000;
        end else if (convDone) begin
            convResult <= filterData;
        end
    end

    acc_comparator u_comp (
        .ref_clk(ref_clk),
        .srst(rst),
        .eval(convDone),
        .result(filterData),
        .limits(limits),
        .windowMode(runCfg.windowMode),
        .faultQueue(cfg.faultQueue),
        .trigger(trigger),
        .clearCond(clearCond),
        .statusHigh(statusHigh)
    );

    // ==========================================================
    // comparator alert; a new trigger beats a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            alertFlag <= 1'b0;
        end else if (trigger) begin
            alertFlag <= 1'b1;
        end else if (cfg.alertLatchEnable ? (araWon || resultRead) : clearCond) begin
            alertFlag <= 1'b0;
        end
    end

    // only latched alerts take part in the alert response
    assign alertPending = alertFlag && cfg.alertLatchEnable && !readyMode;
    assign alertStatusBit = statusHigh;

    // ==========================================================
    // ready flag: level in single shot, timed pulse in continuous
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            readyLevel <= 1'b0;
        end else if (convDone && cfg.singleShot) begin
            readyLevel <= 1'b1;
        end else if (timerLoad && loadWake) begin
            // any wake from power-down, continuous too, drops the level
            readyLevel <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pulseTicks <= 8'h00;
        end else if (convDone && !cfg.singleShot) begin
            pulseTicks <= 8'(`ACC_RDY_TICKS);
        end else if (tick && pulseTicks != 8'h00) begin
            pulseTicks <= pulseTicks - 8'h01;
        end
    end
    assign readyPulse = (pulseTicks != 8'h00);

    // ==========================================================
    // open-drain pin; pulls low only, never drives high
    assign pinAsserted = readyMode ? (readyLevel || readyPulse) : alertFlag;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            alertPinOe <= 1'b0;
        end else if (cfg.faultQueue == `ACC_QUEUE_OFF) begin
            alertPinOe <= 1'b0;
        end else begin
            // polarity 0 pulls low when asserted, 1 pulls low when idle
            alertPinOe <= pinAsserted ^ cfg.alertPolarity;
        end
    end
    assign alertPinOut = 1'b0;

    // ==========================================================
    // register read word by pointer; the slave shifts MSB byte first
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            readWord <= 16'h0000;
        end else begin
            case (pointer)
                `ACC_PTR_CONV: readWord <= convResult;
                `ACC_PTR_CFG: readWord <= {conversionStartBit, 6'h00, cfg};
                `ACC_PTR_LOWER: readWord <= limits.lowerLimit;
                default: readWord <= limits.upperLimit;
            endcase
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    sequence s_conv_end_single;
        convDone && cfg.singleShot && !rst;
    endsequence
    sequence s_conv_end_cont;
        convDone && !cfg.singleShot && !rst;
    endsequence

    a_reset_defaults: assert property ($fell(srst) |-> state == acc_pkg::ST_OFF
        && cfg.singleShot && cfg.faultQueue == `ACC_QUEUE_OFF && !alertPinOe)
        else $error("reset did not restore power-down defaults");
    a_gc_reset_off: assert property ((gcByte && gcCommand == `ACC_GC_RESET)
        |=> state == acc_pkg::ST_OFF && cfg.singleShot)
        else $error("general call reset ignored");
    a_single_powers_down: assert property (s_conv_end_single
        |=> state == acc_pkg::ST_OFF && conversionStartBit)
        else $error("single shot did not power down");
    a_cont_restarts: assert property (s_conv_end_cont
        |=> state == acc_pkg::ST_CONV && convResult == $past(filterData))
        else $error("continuous conversion did not store and restart");
    a_busy_start_ignored: assert property ((state == acc_pkg::ST_CONV && startReq
        && !timerDone && !rst) |=> state == acc_pkg::ST_CONV)
        else $error("start during conversion was not ignored");
    a_queue_off_release: assert property ((cfg.faultQueue == `ACC_QUEUE_OFF && !rst)
        |=> !alertPinOe) else $error("disabled pin still pulled low");
    a_pin_never_high: assert property (alertPinOut == 1'b0)
        else $error("open-drain pin drove high");
    a_latch_holds: assert property ((alertFlag && cfg.alertLatchEnable && !araWon
        && !resultRead && !rst && !cfgWrite) |=> alertFlag)
        else $error("latched alert dropped without clear");
    a_ara_clears: assert property ((araWon && alertPending && !trigger && !rst
        && !cfgWrite) |=> !alertFlag) else $error("won alert response kept alert");
    a_ready_pulse: assert property ((s_conv_end_cont ##1 readyMode)
        |-> readyPulse [*8]) else $error("ready pulse too short");
endmodule
`default_nettype wire

// >>> shared/acc_defines.svh
/*
 * Constants of the converter control block: clock rates, timing counts,
 * reset values of the configuration, command codes and pointer codes.
 * Assumes it is included by bare name by every design file that needs it.
 */
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH

// ==========================================================
// clocks and timing
`define ACC_CLK_HZ 20000000
`define ACC_OSC_HZ 1000000
`define ACC_OSC_DIV (`ACC_CLK_HZ / `ACC_OSC_HZ)
`define ACC_PWRUP_US 25
`define ACC_PWRUP_TICKS ((`ACC_PWRUP_US * `ACC_OSC_HZ + 999999) / 1000000)
`define ACC_RDY_US 8
`define ACC_RDY_TICKS ((`ACC_RDY_US * `ACC_OSC_HZ) / 1000000)

// ==========================================================
// output data rates in samples per second, by rate_select code
`define ACC_SPS_0 8
`define ACC_SPS_1 16
`define ACC_SPS_2 32
`define ACC_SPS_3 64
`define ACC_SPS_4 128
`define ACC_SPS_5 250
`define ACC_SPS_6 475
`define ACC_SPS_7 860

// ==========================================================
// configuration and limit reset values
`define ACC_RST_MODE 1'b1
`define ACC_RST_RATE 3'h4
`define ACC_RST_WINDOW 1'b0
`define ACC_RST_POL 1'b0
`define ACC_RST_LATCH 1'b0
`define ACC_RST_QUEUE 2'h3
`define ACC_RST_UPPER 16'h7fff
`define ACC_RST_LOWER 16'h8000

// ==========================================================
// codes
`define ACC_QUEUE_OFF 2'h3
`define ACC_ARA_ADDR 8'h19
`define ACC_GC_RESET 8'h06
`define ACC_PTR_CONV 2'h0
`define ACC_PTR_CFG 2'h1
`define ACC_PTR_LOWER 2'h2
`define ACC_PTR_UPPER 2'h3

`endif

// >>> shared/acc_pkg.sv
/*
 * Types of the converter control block.
 * Assumes constants come from acc_defines.svh.
 */
package acc_pkg;
    // ==========================================================
    // configuration word
    typedef struct packed {
        logic singleShot;
        logic [2:0] rateSelect;
        logic windowMode;
        logic alertPolarity;
        logic alertLatchEnable;
        logic [1:0] faultQueue;
    } acc_cfg_t;

    // threshold pair, signed two's complement
    typedef struct packed {
        logic signed [15:0] upperLimit;
        logic signed [15:0] lowerLimit;
    } acc_limits_t;

    typedef enum logic [1:0] {ST_OFF, ST_WAKE, ST_CONV} acc_state_t;
endpackage

// >>> design/acc_conv_timer.sv
/*
 * Conversion timer: divides ref_clk down to the 1 MHz oscillator tick and
 * counts ticks for the power-up wait or for one conversion period.
 * Assumes load is a one-cycle pulse from the controller on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "acc_defines.svh"

module acc_conv_timer #(
    parameter int OSC_DIV = `ACC_OSC_DIV
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic load,
    input wire logic loadWake,
    input wire logic [2:0] rateSelect,
    output logic tick,
    output logic done
);
    logic [7:0] divCount;
    logic [16:0] ticksLeft;
    logic running;

    // conversion time equals one over the data rate, truncated to ticks
    function automatic logic [16:0] periodTicks(input logic [2:0] r);
        case (r)
            3'h0: periodTicks = 17'(`ACC_OSC_HZ / `ACC_SPS_0);
            3'h1: periodTicks = 17'(`ACC_OSC_HZ / `ACC_SPS_1);
            3'h2: periodTicks = 17'(`ACC_OSC_HZ / `ACC_SPS_2);
            3'h3: periodTicks = 17'(`ACC_OSC_HZ / `ACC_SPS_3);
            3'h4: periodTicks = 17'(`ACC_OSC_HZ / `ACC_SPS_4);
            3'h5: periodTicks = 17'(`ACC_OSC_HZ / `ACC_SPS_5);
            3'h6: periodTicks = 17'(`ACC_OSC_HZ / `ACC_SPS_6);
            default: periodTicks = 17'(`ACC_OSC_HZ / `ACC_SPS_7);
        endcase
    endfunction

    // ==========================================================
    // oscillator tick, free running so timing never depends on a pin
    always_ff @(posedge ref_clk) begin
        if (srst || divCount == 8'(OSC_DIV - 1)) begin
            divCount <= 8'h00;
        end else begin
            divCount <= divCount + 8'h01;
        end
    end
    assign tick = (divCount == 8'(OSC_DIV - 1));

    // ==========================================================
    // tick down counter; done pulses on the last tick
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ticksLeft <= 17'h00000;
            running <= 1'b0;
        end else if (load) begin
            ticksLeft <= loadWake ? 17'(`ACC_PWRUP_TICKS) : periodTicks(rateSelect);
            running <= 1'b1;
        end else if (running && tick) begin
            ticksLeft <= ticksLeft - 17'h00001;
            if (ticksLeft == 17'h00001) begin
                running <= 1'b0;
            end
        end
    end
    assign done = running && tick && (ticksLeft == 17'h00001); // no load term: load reads done

    // ==========================================================
    // checks
    a_timer_done_once: assert property (@(posedge ref_clk) disable iff (srst)
        done |=> !done) else $error("timer done lasted two cycles");
endmodule
`default_nettype wire

// >>> design/acc_comparator.sv
/*
 * Threshold comparator with fault queue: evaluates one result per
 * conversion and reports trigger, clear condition and which side tripped.
 * Assumes eval is a one-cycle pulse with result valid in that cycle.
 */
`timescale 1ns/1ns
`default_nettype none
`include "acc_defines.svh"

module acc_comparator (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic eval,
    input wire logic signed [15:0] result,
    input wire acc_pkg::acc_limits_t limits,
    input wire logic windowMode,
    input wire logic [1:0] faultQueue,
    output logic trigger,
    output logic clearCond,
    output logic statusHigh
);
    logic [2:0] beyondCount;
    logic aboveHigh;
    logic belowLow;
    logic beyond;
    logic [2:0] need;

    // signed compares on both limits
    assign aboveHigh = result > limits.upperLimit;
    assign belowLow = result < limits.lowerLimit;
    assign beyond = windowMode ? (aboveHigh || belowLow) : aboveHigh;
    // one, two or four successive readings
    assign need = (faultQueue == 2'h0) ? 3'h1 : (faultQueue == 2'h1) ? 3'h2 : 3'h4;

    // ==========================================================
    // successive-reading counter, saturating at four
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            beyondCount <= 3'h0;
        end else if (eval) begin
            if (!beyond) begin
                beyondCount <= 3'h0;
            end else if (beyondCount != 3'h4) begin
                beyondCount <= beyondCount + 3'h1;
            end
        end
    end

    assign trigger = eval && beyond && (beyondCount + 3'h1 >= need);
    // traditional releases only under the low limit: hysteresis
    assign clearCond = eval && (windowMode ? !beyond : belowLow);

    // ==========================================================
    // side that tripped, for the alert response status bit
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            statusHigh <= 1'b0;
        end else if (trigger) begin
            statusHigh <= aboveHigh;
        end
    end

    a_queue_needs_two: assert property (@(posedge ref_clk) disable iff (srst)
        (eval && faultQueue == 2'h1 && beyondCount == 3'h0) |-> !trigger)
        else $error("two-reading queue fired on first reading");
endmodule
`default_nettype wire

// >>> bench/acc_host_model.sv
/*
 * Host controller model: turns register traffic into the decoded one-cycle
 * pulses that the slave front end would deliver, driven at falling edges.
 * Assumes ref_clk from the bench and alertLine as the pulled-up pin level.
 */
`timescale 1ns/1ns
`default_nettype none

module acc_host_model (
    input wire logic ref_clk,
    input wire logic alertLine,
    output acc_pkg::acc_cfg_t cfgIn,
    output logic cfgWrite,
    output logic startIn,
    output logic limitWrite,
    output acc_pkg::acc_limits_t limitsIn,
    output logic regRead,
    output logic [1:0] pointer,
    output logic gcByte,
    output logic [7:0] gcCommand,
    output logic araWon
);
    // ==========================================================
    // idle levels
    initial begin
        {cfgWrite, startIn, limitWrite, regRead, gcByte, araWon} = 6'h00;
        cfgIn = '0;
        limitsIn = '0;
        pointer = 2'h0;
        gcCommand = 8'h00;
    end

    // ==========================================================
    // transfers: fields hold through the taking edge, then show the inverse; rd leaves the pointer
    task automatic cfg(input acc_pkg::acc_cfg_t c, input logic s);
        @(negedge ref_clk);
        {cfgIn, startIn, cfgWrite} = {c, s, 1'b1};
        @(negedge ref_clk);
        {cfgIn, startIn, cfgWrite} = {~c, ~s, 1'b0};
    endtask

    task automatic lim(input acc_pkg::acc_limits_t l);
        @(negedge ref_clk);
        {limitsIn, limitWrite} = {l, 1'b1};
        @(negedge ref_clk);
        {limitsIn, limitWrite} = {~l, 1'b0};
    endtask

    task automatic rd(input logic [1:0] p);
        @(negedge ref_clk);
        {pointer, regRead} = {p, 1'b1};
        @(negedge ref_clk);
        regRead = 1'b0;
    endtask

    task automatic gc(input logic [7:0] b);
        @(negedge ref_clk);
        {gcCommand, gcByte} = {b, 1'b1};
        @(negedge ref_clk);
        {gcCommand, gcByte} = {~b, 1'b0};
    endtask

    // alert response only while the line is seen low; this device wins
    task automatic ara();
        @(negedge ref_clk);
        araWon = (alertLine === 1'b0);
        @(negedge ref_clk);
        araWon = 1'b0;
    endtask
endmodule

`default_nettype wire

// >>> bench/adc_conversion_and_alert_control_tb.sv
/*
 * Self-checking bench of acc_ctrl with the host model on its far side.
 * Assumes OSC_DIV of 2 so one oscillator tick is two ref_clk cycles.
 */
`timescale 1ns/1ns
`default_nettype none
`include "acc_defines.svh"

module adc_conversion_and_alert_control_tb;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [15:0] filterData = 16'h0000;
    logic cfgWrite, startIn, limitWrite, regRead, gcByte, araWon;
    logic [1:0] pointer;
    logic [7:0] gcCommand;
    acc_pkg::acc_cfg_t cfgIn, cfg, c, rstCfg;
    acc_pkg::acc_limits_t limitsIn, limits;
    logic conversionStartBit, alertPending, alertStatusBit, alertPinOut, alertPinOe;
    logic [15:0] convResult, readWord;
    logic [15:0] expQ[$];
    logic prevIdle = 1'b1;
    logic [31:0] rnd = 32'h224edfd2;
    int failCount = 0;
    int cmpCount = 0;
    int n;
    int sps[2] = '{`ACC_SPS_7, `ACC_SPS_6};
    wire logic alertLine;

    // ==========================================================
    // clock, pulled-up pin, instances
    always #25 ref_clk = ~ref_clk;
    assign alertLine = alertPinOe ? alertPinOut : 1'b1;

    acc_ctrl #(.OSC_DIV(2)) dut_u (.ref_clk(ref_clk), .srst(srst), .cfgWrite(cfgWrite),
        .cfgIn(cfgIn), .startIn(startIn), .limitWrite(limitWrite), .limitsIn(limitsIn),
        .regRead(regRead), .pointer(pointer), .gcByte(gcByte), .gcCommand(gcCommand),
        .araWon(araWon), .filterData(filterData), .cfg(cfg), .limits(limits),
        .conversionStartBit(conversionStartBit), .convResult(convResult),
        .readWord(readWord), .alertPending(alertPending), .alertStatusBit(alertStatusBit),
        .alertPinOut(alertPinOut), .alertPinOe(alertPinOe));

    acc_host_model host_u (.ref_clk(ref_clk), .alertLine(alertLine), .cfgIn(cfgIn),
        .cfgWrite(cfgWrite), .startIn(startIn), .limitWrite(limitWrite),
        .limitsIn(limitsIn), .regRead(regRead), .pointer(pointer), .gcByte(gcByte),
        .gcCommand(gcCommand), .araWon(araWon));

    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            failCount++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic testDone;
        $display("compares %0d mismatches %0d", cmpCount, failCount);
        if (failCount == 0 && cmpCount > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // one single-shot conversion; again retries the start while busy
    task automatic conv(input acc_pkg::acc_cfg_t k, input logic [15:0] d, input bit again);
        filterData = d;
        expQ.push_back(d);
        host_u.cfg(k, 1'b1);
        n = 1;
        while (conversionStartBit !== 1'b1) begin
            @(negedge ref_clk);
            n++;
            if (again && n == 50) begin
                host_u.cfg(k, 1'b1);
                n += 2;
            end
            if (n > 6000) begin
                failCount++;
                testDone();
            end
        end
        filterData = ~d; // sample only counts at conversion end
        repeat (2) @(negedge ref_clk);
    endtask

    // ==========================================================
    // monitor: each return to power-down after a conversion takes the oldest note
    always @(negedge ref_clk) begin
        if (!srst && conversionStartBit === 1'b1 && prevIdle === 1'b0 && expQ.size() > 0)
            chk(convResult, expQ.pop_front());
        prevIdle = conversionStartBit;
    end

    // ==========================================================
    // main sequence
    initial begin
        rstCfg = {`ACC_RST_MODE, `ACC_RST_RATE, `ACC_RST_WINDOW, `ACC_RST_POL,
            `ACC_RST_LATCH, `ACC_RST_QUEUE};
        repeat (5) @(negedge ref_clk);
        srst = 1'b0;
        chk(cfg, rstCfg);
        chk(limits, 32'h7fff8000);
        chk({conversionStartBit, alertPinOe, alertLine}, 3'h5);
        // conversion time per rate, with an ignored start mid-way
        c = rstCfg;
        for (int i = 0; i < 2; i++) begin
            c.rateSelect = 3'h7 - 3'(i);
            rnd = lfsr(rnd);
            conv(c, rnd[15:0], i == 1);
            chk(n >= 2 * (25 + 1000000 / sps[i]) - 2 && n <= 2 * (27 + 1000000 / sps[i]) + 4,
                1);
        end
        host_u.lim({16'h0064, 16'hff9c});
        host_u.rd(2'h3);
        repeat (2) @(negedge ref_clk);
        chk(readWord, 16'h0064);
        // latched traditional alert with a two-reading queue
        c.alertLatchEnable = 1'b1;
        c.faultQueue = 2'h1;
        conv(c, 16'h00c8, 0);
        chk(alertPinOe, 1'b0);
        conv(c, 16'h00c8, 0);
        chk({alertPinOe, alertLine, alertPending, alertStatusBit}, 4'hb);
        conv(c, 16'h0000, 0);
        chk(alertPinOe, 1'b1);
        host_u.ara();
        repeat (2) @(negedge ref_clk);
        chk({alertPinOe, alertPending}, 2'h0);
        // window mode, low side, signed compare, cleared by result read
        c.windowMode = 1'b1;
        c.faultQueue = 2'h0;
        conv(c, 16'hff00, 0);
        chk({alertPinOe, alertStatusBit}, 2'h2);
        host_u.rd(2'h0);
        repeat (2) @(negedge ref_clk);
        chk(alertPinOe, 1'b0);
        // active high polarity: inside window the pin is pulled low
        c.alertLatchEnable = 1'b0;
        c.alertPolarity = 1'b1;
        conv(c, 16'h0000, 0);
        chk(alertPinOe, 1'b1);
        // ready mode: single-shot completion pulls the pin low
        host_u.lim({16'h8000, 16'h0000});
        c.alertPolarity = 1'b0;
        rnd = lfsr(rnd);
        conv(c, rnd[15:0], 0);
        chk(alertPinOe, 1'b1);
        // continuous: one ready pulse per conversion, then back to single shot
        rnd = lfsr(rnd);
        filterData = rnd[15:0];
        c.singleShot = 1'b0;
        c.rateSelect = 3'h7;
        host_u.cfg(c, 1'b0);
        repeat (4) @(negedge ref_clk);
        chk(alertPinOe, 1'b0);
        for (n = 0; alertPinOe !== 1'b1; n++) begin
            if (n > 6000) begin
                failCount++;
                testDone();
            end
            @(negedge ref_clk);
        end
        repeat (13) @(negedge ref_clk);
        chk({alertPinOe, conversionStartBit}, 2'h2);
        repeat (4) @(negedge ref_clk);
        chk(alertPinOe, 1'b0);
        c.singleShot = 1'b1;
        conv(c, rnd[15:0], 0);
        c.faultQueue = `ACC_QUEUE_OFF;
        conv(c, 16'h7000, 0);
        chk({alertPinOe, alertLine}, 2'h1);
        // only command 06h resets
        host_u.gc(8'h05);
        repeat (2) @(negedge ref_clk);
        chk(cfg, c);
        host_u.gc(`ACC_GC_RESET);
        repeat (2) @(negedge ref_clk);
        chk({cfg, limits}, {rstCfg, 32'h7fff8000});
        chk(expQ.size(), 0);
        testDone();
    end
endmodule

`default_nettype wire
